// ===== rtl/dramif_ctrl.sv
/*
 * DRAM direct interface: AXI4-Lite register file, access sequencer for
 * area three, page burst with row hold, CAS-before-RAS refresh.
 * Assumes one 125 MHz clock; CPU requester holds a request until ready.
 */
`timescale 1ns/1ns
`default_nettype none
module dramif_ctrl #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // CPU access port for area three
  input wire logic cpu_req_valid,
  input wire dramif_pkg::dramif_req_t cpu_req,
  output logic cpu_req_ready,
  output logic cpu_done,
  output logic [31:0] cpu_rdata,
  // DRAM pins
  output logic [26:1] dram_addr,
  output logic dram_ras_n,
  output logic [3:0] col_strobe_n,
  output logic dram_rd_wr_n,
  output logic [31:0] dram_wdata,
  output logic dram_wdata_oe,
  input wire logic [31:0] dram_rdata,
  input wire logic dram_wait_n,
  input wire logic [3:0] ord_wr_strobe_n
);
  import dramif_pkg::*;

  logic [15:0] bus_control_reg_one, memory_control_reg, wait_control_reg;
  logic [15:0] refresh_timer_ctrl;
  logic [CNT_W-1:0] refresh_compare_value, refresh_counter;
  logic aw_got_r, w_got_r, wr_fire, cnt_load;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic wr_hit, rd_hit;
  logic [2:0] memory_type_select;
  logic width32, precharge_extend, row_col_delay_extend;
  logic [1:0] addr_mux_select, area_three_wait_count, wait_states;
  logic page_burst_enable, row_hold_mode, refresh_mode_select;
  logic refresh_enable, refresh_row_width, is_dram, refresh_enable_match;
  dramif_state_t st_r, st_nxt;
  dramif_req_t cur_r;
  dramif_ctl_t ctl_r, ctl_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic refresh_enable_pend_r, refresh_enable_go, same_row, row_phase_nxt, hold_ok;
  logic [26:1] src_addr, mux_addr;
  logic [3:0] lane_mask, src_be;

  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] val, input logic [3:0] strb);
    merge = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic [26:1] row_key(input logic [26:1] a,
      input logic [1:0] sel);
    row_key = a >> (COL_BITS_BASE + int'(sel));
  endfunction : row_key

  // ****************************************
  // Register fields
  // ****************************************
  // The reserved mux bit is stored but never used by the sequencer
  assign memory_type_select = bus_control_reg_one[BC_TYPE_LSB +: 3];
  assign width32 = bus_control_reg_one[BC_WIDTH32_BIT];
  assign precharge_extend = memory_control_reg[MC_TRP_BIT];
  assign row_col_delay_extend = memory_control_reg[MC_RCD_BIT];
  assign addr_mux_select = memory_control_reg[MC_AMX_LSB +: 2];
  assign page_burst_enable = memory_control_reg[MC_BURST_BIT];
  assign row_hold_mode = memory_control_reg[MC_RHOLD_BIT];
  assign refresh_mode_select = memory_control_reg[MC_REFRESH_MODE_SELECT_BIT];
  assign refresh_enable = memory_control_reg[MC_RFEN_BIT];
  assign refresh_row_width = memory_control_reg[MC_RWIDTH_BIT];
  assign area_three_wait_count = wait_control_reg[WC_WAIT_LSB +: 2];
  assign is_dram = (memory_type_select == MEM_TYPE_DRAM);
  assign lane_mask = width32 ? 4'hf : 4'h3;
  assign wait_states = (area_three_wait_count > WAIT_STATES_MAX) ?
                       WAIT_STATES_MAX : area_three_wait_count;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_r && w_got_r;
  assign wr_hit = awaddr_r inside {OFS_BUS_CTRL, OFS_MEM_CTRL, OFS_WAIT_CTRL,
                  OFS_REFRESH_ENABLE_CTRL, OFS_REFRESH_ENABLE_CNT, OFS_REFRESH_ENABLE_CMP, OFS_STATUS};
  assign cnt_load = wr_fire && awaddr_r == OFS_REFRESH_ENABLE_CNT && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_control_reg_one <= RST_BUS_CTRL;
      memory_control_reg <= RST_MEM_CTRL;
      wait_control_reg <= RST_WAIT_CTRL;
      refresh_timer_ctrl <= RST_REFRESH_ENABLE_CTRL;
      refresh_compare_value <= CNT_W'(RST_REFRESH_ENABLE_CMP);
    end else if (wr_fire) begin
      case (awaddr_r)
        OFS_BUS_CTRL: bus_control_reg_one <=
          merge(bus_control_reg_one, wdata_r, wstrb_r) & 16'h000f;
        OFS_MEM_CTRL: memory_control_reg <=
          merge(memory_control_reg, wdata_r, wstrb_r) & 16'h03ff;
        OFS_WAIT_CTRL: wait_control_reg <=
          merge(wait_control_reg, wdata_r, wstrb_r) & 16'h0003;
        OFS_REFRESH_ENABLE_CTRL: refresh_timer_ctrl <=
          merge(refresh_timer_ctrl, wdata_r, wstrb_r) & 16'h0007;
        OFS_REFRESH_ENABLE_CMP: if (wstrb_r[0]) refresh_compare_value <=
          wdata_r[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_BUS_CTRL: rd_mux = {16'h0000, bus_control_reg_one};
      OFS_MEM_CTRL: rd_mux = {16'h0000, memory_control_reg};
      OFS_WAIT_CTRL: rd_mux = {16'h0000, wait_control_reg};
      OFS_REFRESH_ENABLE_CTRL: rd_mux = {16'h0000, refresh_timer_ctrl};
      OFS_REFRESH_ENABLE_CNT: rd_mux = 32'(refresh_counter);
      OFS_REFRESH_ENABLE_CMP: rd_mux = 32'(refresh_compare_value);
      OFS_STATUS: rd_mux = {29'h0000_0000, !ctl_r.ras_n, refresh_enable_pend_r,
                            st_r != ST_IDLE};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Refresh request
  // ****************************************
  dramif_refresh_enable_timer #(.CNT_W(CNT_W)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(refresh_timer_ctrl[RC_CKS_LSB +: 3]),
    .compare(refresh_compare_value),
    .load(cnt_load),
    .load_val(wdata_r[CNT_W-1:0]),
    .count(refresh_counter),
    .match(refresh_enable_match)
  );

  // One flag only: a match while pending replaces, never queues
  always_ff @(posedge aclk) begin
    if (!aresetn) refresh_enable_pend_r <= 1'b0;
    else refresh_enable_pend_r <= refresh_enable_match || (refresh_enable_pend_r && st_nxt != ST_RPRE);
  end
  assign refresh_enable_go = refresh_enable_pend_r && refresh_enable && !refresh_mode_select &&
                   is_dram;

  // ****************************************
  // Access sequencer
  // ****************************************
  // Refresh only starts where a bus cycle has ended
  assign cpu_req_ready = cpu_req_valid && is_dram && !refresh_enable_go &&
                         (st_r == ST_IDLE || st_r == ST_CAP);
  assign same_row = page_burst_enable && !ctl_r.ras_n &&
    row_key(cpu_req.addr, addr_mux_select) ==
    row_key(cur_r.addr, addr_mux_select);
  assign hold_ok = page_burst_enable && row_hold_mode && !ctl_r.ras_n;

  always_comb begin
    st_nxt = st_r;
    wcnt_nxt = wcnt_r;
    case (st_r)
      ST_IDLE, ST_CAP: begin
        if (cpu_req_ready) begin
          if (same_row) st_nxt = ST_COL;
          else if (!ctl_r.ras_n) st_nxt = ST_PRE;
          else if (st_r == ST_IDLE) st_nxt = ST_PRE;
          else st_nxt = precharge_extend ? ST_PREW : ST_ROW;
        end else if (refresh_enable_go) begin
          st_nxt = ST_RPRE;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_PRE: st_nxt = precharge_extend ? ST_PREW : ST_ROW;
      ST_PREW: st_nxt = ST_ROW;
      ST_ROW: st_nxt = row_col_delay_extend ? ST_ROWW : ST_COL;
      ST_ROWW: st_nxt = ST_COL;
      ST_COL: begin
        wcnt_nxt = wait_states - 2'h1;
        st_nxt = (wait_states == 2'h0) ? ST_CAP : ST_CWAIT;
      end
      ST_CWAIT: begin
        if (wcnt_r != 2'h0) wcnt_nxt = wcnt_r - 2'h1;
        else if (area_three_wait_count != 2'h0 && !dram_wait_n)
          st_nxt = ST_CWAIT;
        else st_nxt = ST_CAP;
      end
      ST_RPRE: st_nxt = precharge_extend ? ST_RPREW : ST_RCAS;
      ST_RPREW: st_nxt = ST_RCAS;
      ST_RCAS: begin
        st_nxt = ST_RRAS;
        wcnt_nxt = refresh_row_width ? REFRESH_ENABLE_RAS_LONG : REFRESH_ENABLE_RAS_SHORT;
      end
      ST_RRAS: begin
        wcnt_nxt = wcnt_r - 2'h1;
        if (wcnt_r == 2'h1) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // ****************************************
  // Pin control
  // ****************************************
  assign src_addr = cpu_req_ready ? cpu_req.addr : cur_r.addr;
  assign src_be = cpu_req_ready ? cpu_req.be : cur_r.be;
  assign row_phase_nxt = st_nxt inside {ST_PRE, ST_PREW, ST_ROW, ST_ROWW};

  dramif_addr_mux u_amux (
    .addr(src_addr),
    .mux_sel(addr_mux_select),
    .row_phase(row_phase_nxt),
    .addr_out(mux_addr)
  );

  always_comb begin
    ctl_nxt.ras_n = !(st_nxt inside {ST_ROW, ST_ROWW, ST_COL, ST_CWAIT,
      ST_RRAS} || (st_nxt == ST_CAP && page_burst_enable) ||
      (st_nxt == ST_IDLE && hold_ok));
    ctl_nxt.cas_n = 4'hf;
    if (st_nxt inside {ST_COL, ST_CWAIT})
      ctl_nxt.cas_n = ~(src_be & lane_mask);
    else if (st_nxt inside {ST_RCAS, ST_RRAS})
      ctl_nxt.cas_n = ~lane_mask;
    ctl_nxt.rd_wr_n = !(cpu_req_ready ? cpu_req.write : cur_r.write) ||
                      !(st_nxt inside {ST_ROW, ST_ROWW, ST_COL, ST_CWAIT});
    ctl_nxt.wdata_oe = !ctl_nxt.rd_wr_n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      wcnt_r <= 2'h0;
      ctl_r <= '{ras_n: 1'b1, cas_n: 4'hf, rd_wr_n: 1'b1, wdata_oe: 1'b0};
      dram_addr <= '0;
    end else begin
      st_r <= st_nxt;
      wcnt_r <= wcnt_nxt;
      ctl_r <= ctl_nxt;
      dram_addr <= mux_addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_r <= '0;
      cpu_rdata <= 32'h0000_0000;
    end else begin
      if (cpu_req_ready) cur_r <= cpu_req;
      if (st_r inside {ST_COL, ST_CWAIT} && st_nxt == ST_CAP && !cur_r.write)
        cpu_rdata <= dram_rdata;
    end
  end

  // Shared pins: ordinary-area write strobes reach the DRAM too
  assign col_strobe_n = ctl_r.cas_n & ord_wr_strobe_n;
  assign dram_ras_n = ctl_r.ras_n;
  assign dram_rd_wr_n = ctl_r.rd_wr_n;
  assign dram_wdata_oe = ctl_r.wdata_oe;
  assign dram_wdata = cur_r.wdata;
  assign cpu_done = (st_r == ST_CAP);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_upper_pass: assert property (aresetn |=>
    dram_addr[26:14] == $past(src_addr[26:14]))
    else $error("Upper address pins not passed through");
  chk_type_gate: assert property (cpu_req_ready |-> is_dram)
    else $error("Access taken outside DRAM mode");
  chk_upper_idle: assert property (!width32 |-> ctl_r.cas_n[3:2] == 2'h3)
    else $error("Upper strobes used in 16-bit mode");
  chk_lane_cas: assert property (st_r == ST_COL |->
    ctl_r.cas_n == ~(cur_r.be & lane_mask))
    else $error("Column strobes do not follow byte lanes");
  chk_basic_seq: assert property (st_r == ST_PRE && !precharge_extend &&
    !row_col_delay_extend && area_three_wait_count == 2'h0 |=>
    st_r == ST_ROW ##1 st_r == ST_COL ##1 st_r == ST_CAP)
    else $error("Basic access sequence broken");
  chk_overlap: assert property (st_r == ST_CAP && cpu_req_ready &&
    ctl_r.ras_n && !precharge_extend |=> st_r == ST_ROW)
    else $error("Precharge not overlapped with capture");
  chk_pre_ext: assert property (st_r == ST_PRE && precharge_extend |=>
    st_r == ST_PREW ##1 st_r == ST_ROW)
    else $error("Precharge extension wrong");
  chk_rcd_ext: assert property (st_r == ST_ROW && row_col_delay_extend |=>
    st_r == ST_ROWW ##1 st_r == ST_COL && !ctl_r.ras_n)
    else $error("Row to column delay wrong");
  chk_no_wait: assert property (st_r == ST_COL &&
    area_three_wait_count == 2'h0 |=> st_r == ST_CAP)
    else $error("Unwanted wait state");
  chk_ext_wait: assert property (st_r == ST_CWAIT && wcnt_r == 2'h0 &&
    area_three_wait_count != 2'h0 && !dram_wait_n |=> st_r == ST_CWAIT)
    else $error("External wait ignored");
  chk_page_reuse: assert property (st_r == ST_CAP && cpu_req_ready &&
    same_row |=> st_r == ST_COL && !dram_ras_n)
    else $error("Open row not reused");
  chk_row_hold: assert property (st_r == ST_CAP && st_nxt == ST_IDLE &&
    page_burst_enable && row_hold_mode |=> !dram_ras_n [*2])
    else $error("Row strobe not held");
  chk_refresh_enable_start: assert property (st_r == ST_IDLE && refresh_enable_go &&
    !cpu_req_ready |=> st_r == ST_RPRE && dram_ras_n)
    else $error("Refresh not started");
  chk_refresh_enable_width: assert property (st_r == ST_RCAS && refresh_row_width |=>
    (st_r == ST_RRAS && !dram_ras_n) [*2] ##1 st_r == ST_IDLE)
    else $error("Refresh row strobe width wrong");
  chk_cbr_order: assert property (st_r == ST_RCAS |-> dram_ras_n &&
    ctl_r.cas_n == ~lane_mask ##1 !dram_ras_n)
    else $error("Column before row order broken");
  chk_refresh_enable_defer: assert property (st_r inside {ST_ROW, ST_COL} |=>
    st_r != ST_RPRE)
    else $error("Refresh broke into a bus cycle");
endmodule : dramif_ctrl
`default_nettype wire

// ===== include/dramif_pkg.sv
/*
 * Constants, field layout, carrier types and state codes of the DRAM
 * direct interface.
 * Assumes a single 125 MHz clock and a 32-bit AXI4-Lite register port.
 */
`default_nettype none
package dramif_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MEM_CTRL = 8'h04;
  localparam logic [7:0] OFS_WAIT_CTRL = 8'h08;
  localparam logic [7:0] OFS_REFRESH_ENABLE_CTRL = 8'h0c;
  localparam logic [7:0] OFS_REFRESH_ENABLE_CNT = 8'h10;
  localparam logic [7:0] OFS_REFRESH_ENABLE_CMP = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BC_TYPE_LSB = 0;
  localparam int BC_WIDTH32_BIT = 3;
  localparam int MC_TRP_BIT = 0;
  localparam int MC_RCD_BIT = 1;
  localparam int MC_AMX_LSB = 2;
  localparam int MC_BURST_BIT = 5;
  localparam int MC_RHOLD_BIT = 6;
  localparam int MC_REFRESH_MODE_SELECT_BIT = 7;
  localparam int MC_RFEN_BIT = 8;
  localparam int MC_RWIDTH_BIT = 9;
  localparam int WC_WAIT_LSB = 0;
  localparam int RC_CKS_LSB = 0;
  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [15:0] RST_BUS_CTRL = 16'h0008;
  localparam logic [15:0] RST_MEM_CTRL = 16'h0000;
  localparam logic [15:0] RST_WAIT_CTRL = 16'h0003;
  localparam logic [15:0] RST_REFRESH_ENABLE_CTRL = 16'h0000;
  localparam logic [7:0] RST_REFRESH_ENABLE_CNT = 8'h00;
  localparam logic [7:0] RST_REFRESH_ENABLE_CMP = 8'h00;
  localparam logic [2:0] MEM_TYPE_DRAM = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Timing counts
  // ****************************************
  localparam int COL_BITS_BASE = 8;
  localparam logic [1:0] WAIT_STATES_MAX = 2'h2;
  localparam logic [1:0] REFRESH_ENABLE_RAS_SHORT = 2'h1;
  localparam logic [1:0] REFRESH_ENABLE_RAS_LONG = 2'h2;
  localparam logic [11:0] PRESC_MASK [0:7] = '{12'h000, 12'h003, 12'h00f,
    12'h03f, 12'h0ff, 12'h3ff, 12'h7ff, 12'hfff};
  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic [26:1] addr;
    logic write;
    logic [3:0] be;
    logic [31:0] wdata;
  } dramif_req_t;

  typedef struct packed {
    logic ras_n;
    logic [3:0] cas_n;
    logic rd_wr_n;
    logic wdata_oe;
  } dramif_ctl_t;

  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_PRE = 12'h002,
    ST_PREW = 12'h004,
    ST_ROW = 12'h008,
    ST_ROWW = 12'h010,
    ST_COL = 12'h020,
    ST_CWAIT = 12'h040,
    ST_CAP = 12'h080,
    ST_RPRE = 12'h100,
    ST_RPREW = 12'h200,
    ST_RCAS = 12'h400,
    ST_RRAS = 12'h800
  } dramif_state_t;
endpackage : dramif_pkg
`default_nettype wire

// ===== rtl/dramif_addr_mux.sv
/*
 * Row/column address multiplexer for the DRAM address pins.
 * Assumes the caller registers the result before it reaches the pins.
 */
`timescale 1ns/1ns
`default_nettype none
module dramif_addr_mux (
  // Source
  input wire logic [26:1] addr,
  input wire logic [1:0] mux_sel,
  input wire logic row_phase,
  // Pins
  output logic [26:1] addr_out
);
  import dramif_pkg::*;
  logic [26:1] shifted;

  // ****************************************
  // Multiplexing
  // ****************************************
  always_comb begin
    shifted = addr >> (COL_BITS_BASE + int'(mux_sel));
    addr_out[26:14] = addr[26:14];
    addr_out[13:1] = row_phase ? shifted[13:1] : addr[13:1];
  end

endmodule : dramif_addr_mux
`default_nettype wire

// ===== rtl/dramif_refresh_enable_timer.sv
/*
 * Refresh interval timer: prescaler, up counter and compare match.
 * Assumes software loads compare and counter before selecting a clock.
 */
`timescale 1ns/1ns
`default_nettype none
module dramif_refresh_enable_timer #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [2:0] clk_sel,
  input wire logic [CNT_W-1:0] compare,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // Status
  output logic [CNT_W-1:0] count,
  output logic match
);
  import dramif_pkg::*;
  logic [11:0] presc_r;
  logic [CNT_W-1:0] cnt_r;
  logic match_r;
  logic tick;

  // ****************************************
  // Prescaler
  // ****************************************
  // Select zero stops counting, so software can set up safely first
  assign tick = (clk_sel != 3'h0) &&
                ((presc_r & PRESC_MASK[clk_sel]) == PRESC_MASK[clk_sel]);

  always_ff @(posedge aclk) begin
    if (!aresetn) presc_r <= 12'h000;
    else presc_r <= presc_r + 12'h001;
  end

  // ****************************************
  // Counter and compare
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= CNT_W'(RST_REFRESH_ENABLE_CNT);
      match_r <= 1'b0;
    end else begin
      match_r <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
      end else if (tick) begin
        if (cnt_r == compare) begin
          cnt_r <= '0;
          match_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CNT_W'(1);
        end
      end
    end
  end

  assign count = cnt_r;
  assign match = match_r;

  chk_match_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    match_r && !$past(load) |-> cnt_r == '0)
    else $error("Counter not cleared on match");
  chk_stopped_count: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_sel == 3'h0 && !load |=> $stable(cnt_r))
    else $error("Counter moved with no clock selected");
endmodule : dramif_refresh_enable_timer
`default_nettype wire

// ===== tb/dramif_mem_model.sv
/* Behavioural page-mode DRAM chip for the bench.
   Assumes active-low strobes and column bits on addr[4:1]. */
`timescale 1ns/1ns
`default_nettype none
module dramif_mem_model (
  // Pins
  input wire logic aclk,
  input wire logic [26:1] addr,
  input wire logic ras_n,
  input wire logic [3:0] cas_n,
  input wire logic rd_wr_n,
  input wire logic [31:0] wdata,
  input wire logic slow,
  output logic [31:0] rdata,
  output logic wait_n,
  output logic [13:1] row_q
);
  logic [31:0] mem [0:15];
  logic pras = 1'b1;
  logic [1:0] wc = 2'h0;
  logic [31:0] lastd = 32'h0;
  // Data follows the column strobe at once; a released bus shows the
  // inverse so a stale value never reads as good data
  assign rdata = (&cas_n) ? ~lastd : mem[addr[4:1]];
  initial wait_n = 1'b1;
  always @(posedge aclk) begin
    if (!ras_n && pras) row_q <= addr[13:1];
    pras <= ras_n;
    wc <= (&cas_n) ? 2'h0 : wc + {1'b0, wc != 2'h3};
    wait_n <= !(slow && !(&cas_n) && wc != 2'h3);
    for (int i = 0; i < 4; i++)
      if (!cas_n[i] && !rd_wr_n) mem[addr[4:1]][8*i+:8] <= wdata[8*i+:8];
    if (!(&cas_n)) lastd <= mem[addr[4:1]];
  end
endmodule : dramif_mem_model
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench of dramif_ctrl.
   Assumes the register map and timing of the package. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dramif_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0;
  logic arv = 0, rready = 0, qv = 0, slow = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, d, rdt, qd, wdo, mrd;
  dramif_req_t q = '0;
  logic awr, wr, bv, arr, rv, qr, done, rasn, rwn, oe, wtn;
  logic [1:0] br, rr;
  logic [3:0] csn;
  logic [3:0] ows = 4'hf;
  logic [26:1] da, la = 26'h0123456;
  logic [13:1] row;
  int fail_count = 0, cmp_count = 0, n;
  always #4 aclk = ~aclk;
  dramif_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .cpu_req_valid(qv),
    .cpu_req(q), .cpu_req_ready(qr), .cpu_done(done), .cpu_rdata(qd),
    .dram_addr(da), .dram_ras_n(rasn), .col_strobe_n(csn),
    .dram_rd_wr_n(rwn), .dram_wdata(wdo), .dram_wdata_oe(oe),
    .dram_rdata(mrd), .dram_wait_n(wtn), .ord_wr_strobe_n(ows));
  dramif_mem_model i_mem (.aclk(aclk), .addr(da), .ras_n(rasn),
    .cas_n(csn), .rd_wr_n(rwn), .wdata(wdo), .slow(slow), .rdata(mrd),
    .wait_n(wtn), .row_q(row));
  task chk(input logic [31:0] v, input logic [31:0] e);
    cmp_count++;
    if (v !== e) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, v, e);
    end
  endtask : chk
  task close_out;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task axw(input logic [7:0] a, input logic [31:0] v);
    logic ad, wdn, t;
    ad = 0;
    wdn = 0;
    awv <= 1; awa <= a; wv <= 1; wd <= v; bready <= 1;
    do begin
      @(negedge aclk);
      ad = ad || awr;
      wdn = wdn || wr;
      t = bv;
      @(posedge aclk);
      if (ad) awv <= 0;
      if (wdn) wv <= 0;
    end while (!t);
    bready <= 0;
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] v);
    logic ad, t;
    ad = 0;
    arv <= 1; ara <= a; rready <= 1;
    do begin
      @(negedge aclk);
      ad = ad || arr;
      t = rv;
      v = rdt;
      @(posedge aclk);
      if (ad) arv <= 0;
    end while (!t);
    rready <= 0;
  endtask : axr
  task go(input logic [26:1] a, input logic w, input logic [31:0] v);
    logic t;
    qv <= 1; q <= '{a, w, 4'hf, v};
    do begin @(negedge aclk); t = qr; @(posedge aclk); end while (!t);
  endtask : go
  task fin(output int k);
    k = 0;
    do begin @(negedge aclk); k++; end while (!done);
    @(posedge aclk);
  endtask : fin
  task t_regs;
    axr(OFS_WAIT_CTRL, d); chk(d, 32'h3);
    axr(8'h1c, d); chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    axw(OFS_BUS_CTRL, 32'ha); axw(OFS_WAIT_CTRL, 32'h0);
    axr(OFS_BUS_CTRL, d); chk(d, 32'ha);
  endtask : t_regs
  task t_mux;
    go(la, 1, 32'hcafe0001); qv <= 0; fin(n); chk(n, 4);
    for (int s = 0; s < 4; s++) begin
      axw(OFS_MEM_CTRL, s << 2); go(la, 0, 0); qv <= 0; fin(n);
      chk(row, la[21+s-:13]); chk(qd, 32'hcafe0001);
    end
  endtask : t_mux
  task b2b(input int e);
    go(la, 1, 32'h11); q <= '{la + 26'h1, 1'b1, 4'hf, 32'h22}; n = 0;
    do begin @(negedge aclk); n++; end while (!qr);
    @(posedge aclk);
    chk(n, 4); qv <= 0; fin(n); chk(n, e);
    go(la + 26'h1, 0, 0); qv <= 0; fin(n); chk(qd, 32'h22);
  endtask : b2b
  task t_wait;
    axw(OFS_MEM_CTRL, 32'h3); axw(OFS_WAIT_CTRL, 32'h2);
    go(la, 0, 0); qv <= 0; fin(n); chk(n, 8);
    slow <= 1; go(la, 0, 0); qv <= 0; fin(n); chk(n > 8, 1);
    slow <= 0; chk(qd, 32'h11);
  endtask : t_wait
  task t_hold;
    axw(OFS_MEM_CTRL, 32'h60);
    go(la, 0, 0);
    qv <= 0;
    fin(n);
    ows <= 4'h7;
    @(negedge aclk);
    chk(rasn, 0);
    chk(csn, 4'h7);
    @(posedge aclk);
    ows <= 4'hf;
  endtask : t_hold
  task t_refresh_enable;
    axw(OFS_REFRESH_ENABLE_CMP, 32'h2); axw(OFS_MEM_CTRL, 32'h100);
    axw(OFS_REFRESH_ENABLE_CTRL, 32'h1);
    n = 0;
    do begin @(negedge aclk); n++; end while (rasn && n < 400);
    chk(csn, 4'h0);
    n = 0;
    do begin @(negedge aclk); n++; end while (!rasn);
    chk(n, 1);
    axw(OFS_MEM_CTRL, 32'h300);
    do @(negedge aclk); while (!rasn);
    n = 0;
    do begin @(negedge aclk); n++; end while (rasn && n < 400);
    chk(csn, 4'h0);
    n = 0;
    do begin @(negedge aclk); n++; end while (!rasn);
    chk(n, 2);
  endtask : t_refresh_enable
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_regs; t_mux; b2b(3);
    axw(OFS_MEM_CTRL, 32'h20); b2b(2);
    // Bench skips the power-up hold-off; the model needs none
    t_wait; t_hold; t_refresh_enable; close_out;
  end
  initial begin
    #200000 fail_count++;
    close_out;
  end
endmodule : tb
`default_nettype wire
